// *** verilog/dpl_pkg.sv ***
package dpl_pkg;

  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ADDR_OFS = 8'h04;
  localparam logic [7:0] WDAT_OFS = 8'h08;
  localparam logic [7:0] WDHI_OFS = 8'h0C;
  localparam logic [7:0] RDAT_OFS = 8'h10;
  localparam logic [7:0] RDHI_OFS = 8'h14;
  localparam logic [7:0] STAT_OFS = 8'h18;

  localparam int START_BIT = 0;
  localparam int WR_BIT = 1;
  localparam int SEM_BIT = 2;
  localparam int SIZE_BIT = 4;
  localparam int WEN_BIT = 5;
  localparam int DONE_BIT = 1;
  localparam int ERR_BIT = 2;

  // Bus width codes, written as {width_enable_strap, size_strap}
  localparam logic [1:0] MODE_X36 = 2'h0;
  localparam logic [1:0] MODE_IODIS = 2'h1;
  localparam logic [1:0] MODE_X18 = 2'h2;
  localparam logic [1:0] MODE_X9 = 2'h3;

  localparam logic [35:0] MASK_X9 = 36'h0_0000_01FF;
  localparam logic [35:0] MASK_X18 = 36'h0_0003_FFFF;
  localparam logic [35:0] MASK_X36 = 36'hF_FFFF_FFFF;
  localparam logic [35:0] DQ_RST = 36'h0_0000_0000;

  localparam int CLK_PERIOD_NS = 40;
  localparam int STRAP_SETUP_NS = 40;
  localparam int ACCESS_NS = 80;
  localparam int STRAP_CYC = (STRAP_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_CYC = 3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETTLE = 3'h1,
    ST_SETUP = 3'h2,
    ST_ACCESS = 3'h3,
    ST_RECOVER = 3'h4
  } dpl_state_t;

endpackage : dpl_pkg

// *** verilog/dpl_host.sv ***
`timescale 1ns/1ps
module dpl_host #(
  parameter int AW = 15
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [AW-1:0] mem_addr,
  output logic mem_ce_n,
  output logic mem_rw,
  output logic mem_oe_n,
  output logic mem_sem_n,
  output logic width_enable_strap,
  output logic size_strap,
  output logic half_select,
  output logic quarter_select,
  output logic [35:0] mem_dq_o,
  output logic [35:0] mem_dq_oe,
  input wire logic [35:0] mem_dq_i
);

  dpl_pkg::dpl_state_t state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic [1:0] beat_q, beat_d;
  logic [1:0] mode_q;
  logic wr_q, sem_q, done_q, err_q;
  logic [AW-1:0] areg_q, addr_q;
  logic [35:0] wdat_q;
  logic [8:0] rlane_q [4];
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic ce_n_q, rw_q, oe_n_q, sem_n_q, half_q, quarter_q;
  logic [35:0] dq_o_q, dq_oe_q;
  logic [35:0] s1_q, s2_q, s3_q, dqf_q;

  // APB decode
  wire apb_acc = psel & penable;
  wire apb_first = apb_acc & ~pready_q;
  wire apb_wr = apb_acc & pready_q & pwrite;
  wire hit_ctrl = paddr == dpl_pkg::CTRL_OFS;
  wire hit_addr = paddr == dpl_pkg::ADDR_OFS;
  wire hit_wdat = paddr == dpl_pkg::WDAT_OFS;
  wire hit_wdhi = paddr == dpl_pkg::WDHI_OFS;
  wire hit_rdat = paddr == dpl_pkg::RDAT_OFS;
  wire hit_rdhi = paddr == dpl_pkg::RDHI_OFS;
  wire hit_stat = paddr == dpl_pkg::STAT_OFS;
  wire mapped = hit_ctrl | hit_addr | hit_wdat | hit_wdhi | hit_rdat | hit_rdhi | hit_stat;
  wire idle = state_q == dpl_pkg::ST_IDLE;
  // Data registers are locked while a transfer walks its beats
  wire ctrl_wr = apb_wr & hit_ctrl & idle;
  wire addr_wr = apb_wr & hit_addr & idle;
  wire wdat_wr = apb_wr & hit_wdat & idle;
  wire wdhi_wr = apb_wr & hit_wdhi & idle;
  wire stat_wr = apb_wr & hit_stat;
  wire [1:0] mode_new = {pwdata[dpl_pkg::WEN_BIT], pwdata[dpl_pkg::SIZE_BIT]};
  // Straps only move while idle, so they never change under an access
  wire mode_chg = ctrl_wr & (mode_new != mode_q);
  wire start_req = ctrl_wr & ~mode_chg & pwdata[dpl_pkg::START_BIT];
  // No data path exists in the I/O disable mode
  wire bad_start = start_req & (mode_q == dpl_pkg::MODE_IODIS)
    & ~pwdata[dpl_pkg::SEM_BIT];
  wire go = start_req & ~bad_start;
  // Width steering of the second port
  wire x9 = (mode_q == dpl_pkg::MODE_X9) & ~sem_q;
  wire x18 = (mode_q == dpl_pkg::MODE_X18) & ~sem_q;
  wire x36 = ~x9 & ~x18 & ~sem_q;
  wire [1:0] last_beat = x9 ? 2'h3 : (x18 ? 2'h1 : 2'h0);
  wire [7:0] acc_len = 8'(dpl_pkg::ACC_CYC) + (wr_q ? 8'h00 : 8'(dpl_pkg::SYNC_CYC));
  wire capture = (state_q == dpl_pkg::ST_ACCESS) & (cnt_q == 8'h00) & ~wr_q;
  wire finish = (state_q == dpl_pkg::ST_RECOVER) & (beat_q == last_beat);

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      dpl_pkg::ST_IDLE:
      begin
        if (mode_chg)
        begin
          state_d = dpl_pkg::ST_SETTLE;
          cnt_d = 8'(dpl_pkg::STRAP_CYC);
        end
        else if (go)
          state_d = dpl_pkg::ST_SETUP;
      end
      dpl_pkg::ST_SETTLE, dpl_pkg::ST_ACCESS:
      begin
        if (cnt_q != 8'h00)
          cnt_d = cnt_q - 8'h01;
        else if (state_q == dpl_pkg::ST_SETTLE)
          state_d = dpl_pkg::ST_IDLE;
        else
          state_d = dpl_pkg::ST_RECOVER;
      end
      dpl_pkg::ST_SETUP:
      begin
        state_d = dpl_pkg::ST_ACCESS;
        cnt_d = acc_len - 8'h01;
      end
      dpl_pkg::ST_RECOVER:
        state_d = finish ? dpl_pkg::ST_IDLE : dpl_pkg::ST_SETUP;
      default:
        state_d = dpl_pkg::ST_IDLE;
    endcase
  end

  wire next_beat = (state_q == dpl_pkg::ST_RECOVER) & ~finish;
  assign beat_d = go ? 2'h0 : (next_beat ? beat_q + 2'h1 : beat_q);
  wire act_d = state_d == dpl_pkg::ST_ACCESS;
  // Write data stands through recovery too, for hold time after the strobe
  wire run_d = (state_d != dpl_pkg::ST_IDLE) & (state_d != dpl_pkg::ST_SETTLE);
  // Selects act as extra address bits: they move only between strobes
  wire half_d = run_d & ((x18 & beat_d[0]) | (x9 & beat_d[1]));
  // Held low when ignored or idle rather than left floating
  wire quarter_d = run_d & x9 & beat_d[0];
  wire [35:0] lane_mask = (x9 | sem_q) ? dpl_pkg::MASK_X9
    : (x18 ? dpl_pkg::MASK_X18 : dpl_pkg::MASK_X36);
  wire [35:0] wbyte = {27'h000_0000, wdat_q[9*beat_d +: 9]};
  wire [35:0] wword = {18'h0_0000, wdat_q[18*beat_d[0] +: 18]};
  wire [35:0] dq_o_d = (x9 | sem_q) ? wbyte : (x18 ? wword : wdat_q);
  wire [35:0] dq_oe_d = (wr_q & run_d) ? lane_mask : dpl_pkg::DQ_RST;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q <= dpl_pkg::ST_SETTLE;
      cnt_q <= 8'(dpl_pkg::STRAP_CYC);
      beat_q <= 2'h0;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      beat_q <= beat_d;
    end
  end
  // Control and data registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mode_q <= dpl_pkg::MODE_X36;
      wr_q <= 1'h0;
      sem_q <= 1'h0;
      areg_q <= '0;
      wdat_q <= dpl_pkg::DQ_RST;
      done_q <= 1'h0;
      err_q <= 1'h0;
    end
    else if (clk_en)
    begin
      if (mode_chg)
        mode_q <= mode_new;
      if (ctrl_wr)
      begin
        wr_q <= pwdata[dpl_pkg::WR_BIT];
        sem_q <= pwdata[dpl_pkg::SEM_BIT];
      end
      if (addr_wr)
        areg_q <= pwdata[AW-1:0];
      if (wdat_wr)
        wdat_q[31:0] <= pwdata;
      if (wdhi_wr)
        wdat_q[35:32] <= pwdata[3:0];
      // A completion in the clearing cycle is kept
      done_q <= finish | (done_q & ~(stat_wr & pwdata[dpl_pkg::DONE_BIT]));
      err_q <= bad_start | (err_q & ~(stat_wr & pwdata[dpl_pkg::ERR_BIT]));
    end
  end

  // Pin registers follow the next state so strobes line up with it
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      addr_q <= '0;
      ce_n_q <= 1'h1;
      rw_q <= 1'h1;
      oe_n_q <= 1'h1;
      sem_n_q <= 1'h1;
      half_q <= 1'h0;
      quarter_q <= 1'h0;
      dq_o_q <= dpl_pkg::DQ_RST;
      dq_oe_q <= dpl_pkg::DQ_RST;
    end
    else if (clk_en)
    begin
      if (go)
        addr_q <= areg_q;
      // Semaphore cycles keep the chip enable off
      ce_n_q <= ~(act_d & ~sem_q);
      sem_n_q <= ~(act_d & sem_q);
      rw_q <= ~(act_d & wr_q);
      oe_n_q <= ~(act_d & ~wr_q);
      half_q <= half_d;
      quarter_q <= quarter_d;
      dq_o_q <= dq_o_d;
      dq_oe_q <= dq_oe_d;
    end
  end

  // Three-stage sampler; a bit moves once stages two and three agree
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s1_q <= dpl_pkg::DQ_RST;
      s2_q <= dpl_pkg::DQ_RST;
      s3_q <= dpl_pkg::DQ_RST;
      dqf_q <= dpl_pkg::DQ_RST;
    end
    else if (clk_en)
    begin
      s1_q <= mem_dq_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      dqf_q <= (s2_q & s3_q) | (dqf_q & (s2_q | s3_q));
    end
  end

  // Each stored lane is refilled only by the beat that carries it, except lanes 1 to 3, which a semaphore read clears to zero
  for (genvar l = 0; l < 4; l++)
  begin : g_lane
    wire upd = capture & (x36 | sem_q | (x18 & (beat_q[0] == 1'(l / 2)))
      | (x9 & (beat_q == 2'(l))));
    wire [8:0] src = sem_q ? ((l == 0) ? dqf_q[8:0] : 9'h000)
      : (x9 ? dqf_q[8:0] : (x18 ? dqf_q[9*(l%2) +: 9] : dqf_q[9*l +: 9]));
    always_ff @(posedge clk_sys)
    begin
      if (rst)
        rlane_q[l] <= 9'h000;
      else if (clk_en && upd)
        rlane_q[l] <= src;
    end
  end

  wire [35:0] rdat = {rlane_q[3], rlane_q[2], rlane_q[1], rlane_q[0]};
  wire [31:0] stat = {28'h000_0000, state_q != dpl_pkg::ST_SETTLE, err_q, done_q, ~idle};
  wire [31:0] rd_mux = hit_ctrl ? {26'h000_0000, mode_q, 1'h0, sem_q, wr_q, 1'h0}
    : hit_addr ? 32'(areg_q)
    : hit_wdat ? wdat_q[31:0]
    : hit_wdhi ? {28'h000_0000, wdat_q[35:32]}
    : hit_rdat ? rdat[31:0]
    : hit_rdhi ? {28'h000_0000, rdat[35:32]}
    : hit_stat ? stat : 32'h0000_0000;
  // One wait state: pready rises in the second access-phase cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pready_q <= 1'h0;
      pslverr_q <= 1'h0;
      prdata_q <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      pready_q <= apb_first;
      pslverr_q <= apb_first & ~mapped;
      if (apb_first)
        prdata_q <= rd_mux;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign mem_addr = addr_q;
  assign mem_ce_n = ce_n_q;
  assign mem_rw = rw_q;
  assign mem_oe_n = oe_n_q;
  assign mem_sem_n = sem_n_q;
  assign width_enable_strap = mode_q[1];
  assign size_strap = mode_q[0];
  assign half_select = half_q;
  assign quarter_select = quarter_q;
  assign mem_dq_o = dq_o_q;
  assign mem_dq_oe = dq_oe_q;

  // Checking helpers
  logic [7:0] since_q;
  wire strobe = ~ce_n_q | ~sem_n_q;
  always_ff @(posedge clk_sys)
  begin
    if (rst || (clk_en && mode_chg))
      since_q <= 8'h00;
    else if (clk_en && since_q != 8'hFF)
      since_q <= since_q + 8'h01;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  strap_setup_a: assert property (strobe |-> since_q >= 8'(dpl_pkg::STRAP_CYC))
    else $error("strobe too soon after strap change");
  wen_static_a: assert property (strobe |-> $stable(width_enable_strap))
    else $error("width strap moved during access");
  size_static_a: assert property ($rose(strobe) |-> $stable(size_strap) [*2])
    else $error("size strap moved during access");
  sel_hold_a: assert property ($rose(strobe) |->
    $stable({half_select, quarter_select, mem_addr})
    ##1 (!strobe || $stable({half_select, quarter_select})))
    else $error("select moved around strobe");
  firm_sel_a: assert property (!mode_q[1] |-> !half_select && !quarter_select)
    else $error("ignored select not held low");
  c_x36_wr: cover property (finish && x36 && wr_q);
  c_x18_rd: cover property (finish && x18 && !wr_q);
  c_x9_rd: cover property (finish && x9 && !wr_q);
  c_sem_rd: cover property (finish && sem_q && !wr_q);

endmodule : dpl_host

// *** verif/dpl_mem_model.sv ***
`timescale 1ns/1ps
module dpl_mem_model (
  input wire logic [14:0] mem_addr,
  input wire logic mem_ce_n,
  input wire logic mem_rw,
  input wire logic mem_oe_n,
  input wire logic mem_sem_n,
  input wire logic width_enable_strap,
  input wire logic size_strap,
  input wire logic half_select,
  input wire logic quarter_select,
  input wire logic [35:0] mem_dq_o,
  output logic [35:0] mem_dq_i
);
  logic [35:0] arr [0:15];
  logic [35:0] mlo, word_rd;
  logic [35:0] last_q = 36'h0_0000_0000;
  logic sem_q = 1'b1;
  logic sem_lat = 1'b1;
  int sh;
  wire [1:0] mode = {width_enable_strap, size_strap};
  wire arr_on = !mem_ce_n && mode != dpl_pkg::MODE_IODIS;
  always @*
  begin
    case (mode)
      dpl_pkg::MODE_X18:
      begin
        sh = half_select ? 18 : 0;
        mlo = dpl_pkg::MASK_X18;
      end
      dpl_pkg::MODE_X9:
      begin
        sh = 9 * {half_select, quarter_select};
        mlo = dpl_pkg::MASK_X9;
      end
      default:
      begin
        sh = 0;
        mlo = dpl_pkg::MASK_X36;
      end
    endcase
  end
  // Writes are gated per 9-bit lane, one select to a lane as on the first port
  wire [35:0] wmask = mlo << sh;
  wire [3:0] lane_select = {|wmask[35:27], |wmask[26:18], |wmask[17:9], |wmask[8:0]};
  wire [35:0] lane_bits = {{9{lane_select[3]}}, {9{lane_select[2]}}, {9{lane_select[1]}},
    {9{lane_select[0]}}};
  initial
    for (int k = 0; k < 16; k++)
      arr[k] = 36'h0_0000_0000;
  // Level-sensitive write, as in the real array
  always @*
    if (arr_on && !mem_rw)
      arr[mem_addr[3:0]] = (arr[mem_addr[3:0]] & ~lane_bits) | ((mem_dq_o & mlo) << sh);
  // One port only here, so a grab always has a single winner
  always @*
    if (!mem_sem_n && !mem_rw)
      sem_q = mem_dq_o[0];
  // Latched at read start so a far-side write cannot disturb it
  always @(negedge mem_sem_n)
    sem_lat = sem_q;
  always @(negedge mem_oe_n)
    last_q = word_rd;
  assign word_rd = arr[mem_addr[3:0]] >> sh;
  // Floating lines show the inverse of the last word, never a stale copy
  assign mem_dq_i = mem_oe_n || !mem_rw ? ~last_q
    : arr_on ? (word_rd & mlo) | (~last_q & ~mlo)
    : !mem_sem_n ? {~last_q[35:9], {9{sem_lat}}}
    : ~last_q;
endmodule : dpl_mem_model

// *** verif/test_dual_port_ram_lane_steering.sv ***
`timescale 1ns/1ps
module test_dual_port_ram_lane_steering;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, st;
  logic pready, pslverr, last_err, mem_ce_n, mem_rw, mem_oe_n, mem_sem_n;
  logic width_enable_strap, size_strap, half_select, quarter_select;
  logic [14:0] mem_addr;
  logic [35:0] mem_dq_o, mem_dq_oe, mem_dq_i, rd;
  int num_errors = 0;
  int comparisons = 0;

  dpl_host u_dpl_host (.clk_sys, .rst, .clk_en(1'b1), .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .mem_addr, .mem_ce_n, .mem_rw, .mem_oe_n,
    .mem_sem_n, .width_enable_strap, .size_strap, .half_select, .quarter_select,
    .mem_dq_o, .mem_dq_oe, .mem_dq_i);
  dpl_mem_model u_dpl_mem_model (.mem_addr, .mem_ce_n, .mem_rw, .mem_oe_n, .mem_sem_n,
    .width_enable_strap, .size_strap, .half_select, .quarter_select,
    .mem_dq_o(mem_dq_o & mem_dq_oe), .mem_dq_i);

  initial
    forever #20 clk_sys = ~clk_sys;

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task timed_out;
    num_errors++;
    $display("CHECK FAILED %0t wait ran out", $time);
    wrap_up();
  endtask : timed_out

  task apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do @(posedge clk_sys); while (pready !== 1'b1 && ++i < 50);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 50)
      timed_out();
  endtask : apb

  task poll(input logic [31:0] mask);
    int i;
    for (i = 0; i < 100; i++)
    begin
      apb(dpl_pkg::STAT_OFS, 1'b0, 32'h0000_0000, st);
      if ((st & mask) != 32'h0000_0000)
        return;
    end
    timed_out();
  endtask : poll

  // Straps change only while idle, and no start until they have settled
  task xfer(input logic [1:0] m, input logic [1:0] f, input logic [14:0] a,
    input logic [35:0] d);
    logic [31:0] r;
    apb(dpl_pkg::CTRL_OFS, 1'b1, {26'h000_0000, m, 4'h0}, r);
    poll(32'h0000_0008);
    apb(dpl_pkg::ADDR_OFS, 1'b1, {17'h0_0000, a}, r);
    apb(dpl_pkg::WDAT_OFS, 1'b1, d[31:0], r);
    apb(dpl_pkg::WDHI_OFS, 1'b1, {28'h000_0000, d[35:32]}, r);
    apb(dpl_pkg::CTRL_OFS, 1'b1, {26'h000_0000, m, 1'b0, f, 1'b1}, r);
    poll(32'h0000_0006);
    apb(dpl_pkg::STAT_OFS, 1'b1, 32'h0000_0006, r);
    apb(dpl_pkg::RDAT_OFS, 1'b0, 32'h0000_0000, r);
    rd[31:0] = r;
    apb(dpl_pkg::RDHI_OFS, 1'b0, 32'h0000_0000, r);
    rd[35:32] = r[3:0];
  endtask : xfer

  // Every strobed array beat: no drive on unused lanes, no array beat in I/O-off mode
  always @(posedge clk_sys)
    if (!rst && !mem_ce_n)
    begin
      chk(mem_dq_oe & ~(size_strap ? dpl_pkg::MASK_X9 : dpl_pkg::MASK_X18)
        & {36{width_enable_strap}}, 36'h0_0000_0000);
      chk({35'h0_0000_0000, !width_enable_strap && size_strap}, 36'h0_0000_0000);
    end

  task t_reset;
    logic [31:0] r;
    @(negedge clk_sys);
    chk({30'h0000_0000, width_enable_strap, size_strap, mem_ce_n, mem_oe_n, mem_sem_n,
      |mem_dq_oe}, 36'h0_0000_000E);
    apb(8'h1C, 1'b0, 32'h0000_0000, r);
    chk({35'h0_0000_0000, last_err}, 36'h0_0000_0001);
    $display("t_reset done");
  endtask : t_reset

  // One word written wide, then read back at every width
  task t_wide;
    xfer(dpl_pkg::MODE_X36, 2'h1, 15'h0001, 36'h9_1234_5678);
    xfer(dpl_pkg::MODE_X36, 2'h0, 15'h0001, 36'h0_0000_0000);
    chk(rd, 36'h9_1234_5678);
    xfer(dpl_pkg::MODE_X18, 2'h0, 15'h0001, 36'h0_0000_0000);
    chk(rd, 36'h9_1234_5678);
    xfer(dpl_pkg::MODE_X9, 2'h0, 15'h0001, 36'h0_0000_0000);
    chk(rd, 36'h9_1234_5678);
    $display("t_wide done");
  endtask : t_wide

  // Narrow writes must land in the right lanes of the wide word
  task t_narrow;
    xfer(dpl_pkg::MODE_X9, 2'h1, 15'h0002, 36'hA_BCDE_F012);
    xfer(dpl_pkg::MODE_X36, 2'h0, 15'h0002, 36'h0_0000_0000);
    chk(rd, 36'hA_BCDE_F012);
    xfer(dpl_pkg::MODE_X18, 2'h1, 15'h0003, 36'h5_0F0F_3C3C);
    xfer(dpl_pkg::MODE_X36, 2'h0, 15'h0003, 36'h0_0000_0000);
    chk(rd, 36'h5_0F0F_3C3C);
    $display("t_narrow done");
  endtask : t_narrow

  // I/O-off mode refuses array cycles but still serves semaphores
  task t_sem;
    xfer(dpl_pkg::MODE_IODIS, 2'h1, 15'h0004, 36'h0_0000_0001);
    chk({35'h0_0000_0000, st[dpl_pkg::ERR_BIT]}, 36'h0_0000_0001);
    xfer(dpl_pkg::MODE_X18, 2'h3, 15'h0000, 36'h0_0000_0000);
    xfer(dpl_pkg::MODE_IODIS, 2'h2, 15'h0000, 36'h0_0000_0000);
    chk(rd, 36'h0_0000_0000);
    xfer(dpl_pkg::MODE_IODIS, 2'h3, 15'h0000, 36'h0_0000_0001);
    xfer(dpl_pkg::MODE_X9, 2'h2, 15'h0000, 36'h0_0000_0000);
    chk(rd, 36'h0_0000_01FF);
    $display("t_sem done");
  endtask : t_sem

  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_wide();
    t_narrow();
    t_sem();
    wrap_up();
  end
endmodule : test_dual_port_ram_lane_steering
